// ==== hw/isrp_top.sv ====
// I2C slave receive path with register port and open-drain pins
`include "isrp_cfg.svh"
`default_nettype none
module isrp_top (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            event_flag
);

    isrp_pkg::isrp_state_s q;
    isrp_pkg::isrp_state_s d;

    logic       rise;
    logic       fall;
    logic       start_ev;
    logic       stop_ev;
    logic       busy;
    logic       in_byte;
    logic       is_adr;
    logic       f8;
    logic       f9;
    logic       match;
    logic       hold;
    logic       ovf_c;
    logic       ack_ok;
    logic [7:0] stat;

    // Edges seen on the synchronised copies only
    assign rise     = q.scl_s & ~q.scl_p;
    assign fall     = ~q.scl_s & q.scl_p;
    assign start_ev = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign stop_ev  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

    // Byte position and phase
    assign busy    = q.st != isrp_pkg::ISRP_IDLE;
    assign in_byte = (q.st == isrp_pkg::ISRP_ADDR) | (q.st == isrp_pkg::ISRP_DATA);
    assign is_adr  = q.st == isrp_pkg::ISRP_ADDR;
    assign f8      = fall & in_byte & (q.cnt == `ISRP_BITS_ACK);
    assign f9      = fall & in_byte & (q.cnt == `ISRP_BITS_END);

    // Own address or enabled general call
    assign match = (q.sh[7:1] == q.own[7:1]) // [R23]
                 | (q.con2[`ISRP_C2_GC] & (q.sh == 8'h00)); // [R16]

    // Hold option that applies to the byte just taken
    assign hold = is_adr ? q.con3[`ISRP_C3_AH] : q.con3[`ISRP_C3_DH];

    // Overflow refuses the byte unless override is on
    assign ovf_c  = q.bf | q.con1[`ISRP_C1_OV]; // [R2]
    assign ack_ok = ~ovf_c | q.con3[`ISRP_C3_BO];

    // Status byte as software sees it
    assign stat = {2'h0, q.da, q.pb, q.sb, q.rw, 1'b0, q.bf};

    // Next state of the whole block
    always_comb begin
        d = q;
        d.rdat = 8'h00;

        // Two flops before any logic looks at the pins
        d.scl_m = scl_in;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = sda_in;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;

        // Sequence triggers finish at once; sequencing lives elsewhere
        if (q.con1[`ISRP_C1_MS]) begin
            d.con2 = q.con2 & `ISRP_C2_AUTO; // [R19] [R20]
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                `ISRP_A_BUF: begin
                    if (!busy) begin
                        d.rxb = reg_wdata; // [R22]
                    end
                end
                `ISRP_A_CON1: begin
                    d.con1 = reg_wdata;
                end
                `ISRP_A_CON2: begin
                    // Busy port may clear triggers but never set them
                    d.con2 = {reg_wdata[7], q.con2[6], reg_wdata[5],
                              busy ? (q.con2[4:0] & reg_wdata[4:0])
                                   : reg_wdata[4:0]}; // [R22]
                end
                `ISRP_A_CON3: begin
                    d.con3 = {q.con3[7], reg_wdata[6:0]};
                end
                `ISRP_A_OWN: begin
                    d.own = {reg_wdata[7:1], 1'b0};
                end
                `ISRP_A_EVT: begin
                    d.evt = q.evt & reg_wdata[0]; // [R3]
                end
                default: begin
                end
            endcase
        end

        // Register reads, data stand one cycle later
        if (reg_rd) begin
            case (reg_addr)
                `ISRP_A_BUF: begin
                    d.rdat = q.rxb;
                    d.bf   = 1'b0; // [R7]
                end
                `ISRP_A_STAT: d.rdat = stat;
                `ISRP_A_CON1: d.rdat = q.con1;
                `ISRP_A_CON2: d.rdat = q.con2;
                `ISRP_A_CON3: d.rdat = q.con3;
                `ISRP_A_OWN:  d.rdat = q.own;
                `ISRP_A_EVT:  d.rdat = {7'h00, q.evt};
                default:      d.rdat = 8'h00;
            endcase
        end

        // Software chose the answer and released the clock
        if (q.pend && q.con1[`ISRP_C1_CK]) begin
            d.pend = 1'b0;
            d.sdao = ~q.con2[`ISRP_C2_AD]; // [R12] [R18]
            d.ackd = ~q.con2[`ISRP_C2_AD];
        end

        // Bus conditions first; hardware sets after software clears
        if (start_ev) begin
            d.st   = isrp_pkg::ISRP_ADDR;
            d.cnt  = 4'h0;
            d.sb   = 1'b1; // [R5]
            d.pb   = 1'b0;
            d.sdao = 1'b0;
            d.pend = 1'b0;
            d.ackd = 1'b0;
            d.con3[`ISRP_C3_AT] = 1'b0;
            if (q.con3[`ISRP_C3_SC]) begin
                d.evt = 1'b1; // [R5]
            end
        end else if (stop_ev) begin
            d.st   = isrp_pkg::ISRP_IDLE; // [R8]
            d.pb   = 1'b1; // [R8]
            d.sb   = 1'b0;
            d.sdao = 1'b0;
            d.pend = 1'b0;
            d.ackd = 1'b0;
            d.con3[`ISRP_C3_AT] = 1'b0;
            if (q.con3[`ISRP_C3_PC]) begin
                d.evt = 1'b1; // [R15]
            end
        end else begin
            case (q.st)
                isrp_pkg::ISRP_ADDR,
                isrp_pkg::ISRP_DATA: begin
                    if (rise && q.cnt != `ISRP_BITS_END) begin
                        // Eight data bits, then the answer bit
                        if (q.cnt == `ISRP_BITS_ACK) begin
                            d.con2[`ISRP_C2_AS] = q.sda_s; // [R17]
                        end else begin
                            d.sh = {q.sh[6:0], q.sda_s};
                        end
                        d.cnt = q.cnt + 4'h1;
                    end else if (f8) begin
                        d.con3[`ISRP_C3_AT] = 1'b1; // [R11]
                        if (is_adr && (!match || q.sh[0])) begin
                            // Not ours, or a read: stay off the bus
                            d.st = isrp_pkg::ISRP_SKIP;
                            d.con3[`ISRP_C3_AT] = 1'b0;
                        end else begin
                            d.da = ~is_adr;
                            if (is_adr) begin
                                d.rw = 1'b0; // [R1]
                            end
                            if (q.bf) begin
                                d.con1[`ISRP_C1_OV] = 1'b1;
                            end
                            if (hold) begin
                                // Software decides the answer
                                d.rxb   = q.sh;
                                d.bf    = 1'b1;
                                d.evt   = 1'b1; // [R9] [R10]
                                d.con1[`ISRP_C1_CK] = 1'b0; // [R9] [R10]
                                d.strch = 1'b1;
                                d.pend  = 1'b1;
                            end else if (ack_ok) begin
                                d.rxb  = q.sh; // [R1]
                                d.bf   = 1'b1;
                                d.sdao = 1'b1; // [R6]
                                d.ackd = 1'b1;
                            end
                        end
                    end else if (f9) begin
                        d.sdao = 1'b0;
                        d.cnt  = 4'h0;
                        d.ackd = 1'b0;
                        d.con3[`ISRP_C3_AT] = 1'b0; // [R11]
                        if (q.ackd) begin
                            d.evt = 1'b1; // [R6] [R13] [R3]
                            d.st  = isrp_pkg::ISRP_DATA;
                            if (q.con2[`ISRP_C2_SEN]) begin
                                d.con1[`ISRP_C1_CK] = 1'b0; // [R4] [R14] [R21]
                                d.strch = 1'b1;
                            end
                        end else begin
                            d.st = isrp_pkg::ISRP_SKIP; // [R13]
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Release ends any stretch
        if (d.con1[`ISRP_C1_CK]) begin
            d.strch = 1'b0; // [R4]
        end

        // One extra low cycle gives SDA setup before SCL rises
        d.sclo = (d.strch & ~d.con1[`ISRP_C1_CK]) | q.pend;
    end

    // Single state register, frozen while the enable is low
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q       <= '0;
            q.con1  <= `ISRP_CON1_RST;
            q.con2  <= `ISRP_CON2_RST;
            q.con3  <= `ISRP_CON3_RST;
            q.own   <= `ISRP_OWN_RST;
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_p <= 1'b1;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // Pins are open drain: only ever pulled low
    assign scl_out    = 1'b0;
    assign sda_out    = 1'b0;
    assign scl_oe     = q.sclo;
    assign sda_oe     = q.sdao;
    assign reg_rdata  = q.rdat;
    assign event_flag = q.evt;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_adr_ok;
        clk_en && f8 && is_adr && match && !q.sh[0];
    endsequence

    sequence s_nack9;
        clk_en && f9 && !q.ackd && !q.evt;
    endsequence

    sequence s_release;
        clk_en && q.pend && q.con1[`ISRP_C1_CK];
    endsequence

    a_addr_ack: assert property ( // [R1]
        s_adr_ok ##0 (!hold && ack_ok) |=> q.sdao && !q.rw && q.bf)
        else $error("matching address not acknowledged");

    a_ovf_nack: assert property ( // [R2]
        s_adr_ok ##0 (!hold && !ack_ok) |=> !q.sdao && !q.ackd)
        else $error("address acknowledged during overflow");

    a_evt_sticky: assert property ( // [R3]
        q.evt && !(reg_wr && reg_addr == `ISRP_A_EVT) |=> q.evt)
        else $error("event flag cleared without software");

    a_ack_stretch: assert property ( // [R4]
        clk_en && f9 && q.ackd && q.con2[`ISRP_C2_SEN]
        |=> q.sclo && !q.con1[`ISRP_C1_CK] && q.evt)
        else $error("no stretch after acknowledged byte");

    a_start_flag: assert property ( // [R5]
        clk_en && start_ev && q.con3[`ISRP_C3_SC] |=> q.sb && q.evt && is_adr)
        else $error("start not flagged");

    a_rd_clear: assert property ( // [R7]
        clk_en && reg_rd && reg_addr == `ISRP_A_BUF && !f8 |=> !q.bf)
        else $error("buffer read left buffer full set");

    a_stop_idle: assert property ( // [R8]
        clk_en && stop_ev |=> q.pb && !q.sb && !busy && !q.sdao)
        else $error("stop did not idle the bus");

    a_adr_hold: assert property ( // [R9]
        s_adr_ok ##0 q.con3[`ISRP_C3_AH]
        |=> q.evt && q.pend && !q.con1[`ISRP_C1_CK] ##1 (q.sclo || !clk_en))
        else $error("address hold did not stretch");

    a_dat_hold: assert property ( // [R10]
        clk_en && f8 && !is_adr && q.con3[`ISRP_C3_DH]
        |=> q.evt && q.pend && !q.con1[`ISRP_C1_CK] && q.con3[`ISRP_C3_AT])
        else $error("data hold did not raise event");

    a_hold_send: assert property ( // [R12]
        s_release |=> q.sdao == !$past(q.con2[`ISRP_C2_AD]) && q.sclo && !q.pend)
        else $error("chosen answer not driven");

    a_nack_quiet: assert property ( // [R13]
        s_nack9 |=> !q.evt && !q.sdao && q.st == isrp_pkg::ISRP_SKIP)
        else $error("event raised after not-acknowledge");

    a_stop_quiet: assert property ( // [R15]
        clk_en && stop_ev && !q.con3[`ISRP_C3_PC] && !q.evt |=> !q.evt)
        else $error("stop raised event while disabled");

    a_trig_block: assert property ( // [R22]
        clk_en && busy && reg_wr && reg_addr == `ISRP_A_CON2 && q.con2[4:0] == 5'h00
        |=> q.con2[4:0] == 5'h00)
        else $error("trigger set while busy");

endmodule : isrp_top
`default_nettype wire

// ==== hw/isrp_cfg.svh ====
// Offsets, bit positions and reset values of the I2C slave receive path
// How it works
// [R1] Matching write address clears direction bit, loads buffer, gets acknowledged.
// [R2] Buffer full or overflow set means address is not acknowledged.
// [R3] Event flag set per byte; only software clears it.
// [R4] Stretch enable holds SCL low after each byte until release set.
// [R5] Start sets begin flag; event only with start interrupt enabled.
// [R6] Acked address or plain data byte drives SDA low, raises event.
// [R7] Reading the shift buffer clears buffer full.
// [R8] Stop sets halt flag and returns the bus to idle.
// [R9] Address hold: event and clock release cleared at 8th falling edge.
// [R10] Data hold: event and clock release cleared at 8th falling edge.
// [R11] Acknowledge phase flag shows event came before or after acknowledge.
// [R12] Software writes answer value, then sets release; device sends it.
// [R13] Event after 9th falling edge when acked, never after not-acknowledge.
// [R14] Hold modes with stretch enable also stretch after the acknowledge.
// [R15] Stop without stop interrupt enable raises no event.
// [R16] General call enable accepts address 0x00 as a match.
// [R17] Acknowledge status reads 1 when not acknowledged, 0 when acknowledged.
// [R18] Answer bit value 1 sends not-acknowledge, 0 sends acknowledge.
// [R19] Master mode acknowledge trigger clears itself.
// [R20] Master mode: receive enable; stop, repeated start, start triggers self-clear; the code clears bits 4, 2, 1, 0 but keeps receive enable (bit 3) set.
// [R21] Slave mode bit 0 enables stretching; clear means none.
// [R22] While busy, trigger bits cannot be set, buffer writes are dropped.
// [R23] Upper seven address bits compared with own address, exact match.
`ifndef ISRP_CFG_SVH
`define ISRP_CFG_SVH
`define ISRP_A_BUF  4'h0
`define ISRP_A_STAT 4'h1
`define ISRP_A_CON1 4'h2
`define ISRP_A_CON2 4'h3
`define ISRP_A_CON3 4'h4
`define ISRP_A_OWN  4'h5
`define ISRP_A_EVT  4'h6
`define ISRP_C1_OV  6
`define ISRP_C1_CK  4
`define ISRP_C1_MS  3
`define ISRP_C2_GC  7
`define ISRP_C2_AS  6
`define ISRP_C2_AD  5
`define ISRP_C2_SEN 0
`define ISRP_C2_AUTO 8'he8
`define ISRP_C3_AT  7
`define ISRP_C3_PC  6
`define ISRP_C3_SC  5
`define ISRP_C3_BO  4
`define ISRP_C3_AH  1
`define ISRP_C3_DH  0
`define ISRP_CON1_RST 8'h10
`define ISRP_CON2_RST 8'h00
`define ISRP_CON3_RST 8'h00
`define ISRP_OWN_RST  8'h00
`define ISRP_BITS_ACK 4'h8
`define ISRP_BITS_END 4'h9
`endif

// ==== hw/isrp_pkg.sv ====
// Types of the I2C slave receive path
`default_nettype none
package isrp_pkg;
    typedef enum logic [1:0] {
        ISRP_IDLE,
        ISRP_ADDR,
        ISRP_DATA,
        ISRP_SKIP
    } isrp_st_e;

    typedef struct packed {
        isrp_st_e   st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] rxb;
        logic [7:0] own;
        logic [7:0] con1;
        logic [7:0] con2;
        logic [7:0] con3;
        logic [7:0] rdat;
        logic       bf;
        logic       rw;
        logic       sb;
        logic       pb;
        logic       da;
        logic       evt;
        logic       ackd;
        logic       pend;
        logic       strch;
        logic       sclo;
        logic       sdao;
        logic       scl_m;
        logic       scl_s;
        logic       scl_p;
        logic       sda_m;
        logic       sda_s;
        logic       sda_p;
    } isrp_state_s;
endpackage : isrp_pkg
`default_nettype wire

// ==== tb/isrp_master_model.sv ====
// Behavioural I2C bus master driving SCL and SDA against pull-ups
`default_nettype none
module isrp_master_model (
    input  wire logic clock,
    input  wire logic scl_w,
    input  wire logic sda_w,
    output logic      m_scl,
    output logic      m_sda
);
    timeunit 1ns;
    timeprecision 1ns;

    // Both lines released at time zero
    initial begin
        m_scl = 1'b1;
        m_sda = 1'b1;
    end

    // Half of the 160 ns bit period
    task automatic half;
        repeat (8) @(posedge clock);
    endtask : half

    // Release SCL; a stretching slave holds it, so wait, but bounded
    task automatic rise;
        m_scl <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 2000 && !scl_w; i++) @(posedge clock);
        half;
    endtask : rise

    // SDA falls while SCL is high
    task automatic start;
        @(posedge clock);
        m_sda <= 1'b0;
        half;
        m_scl <= 1'b0;
        half;
    endtask : start

    // One bit; the line is sampled just before SCL falls
    task automatic put(input logic b, output logic a);
        @(posedge clock);
        m_sda <= b;
        half;
        rise;
        a = sda_w;
        m_scl <= 1'b0;
    endtask : put

    // Eight bits, most significant first
    task automatic bits8(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) put(b[i], a);
    endtask : bits8

    // Ninth bit with SDA released; low means acknowledged
    task automatic ackbit(output logic a);
        put(1'b1, a);
    endtask : ackbit

    // SDA rises while SCL is high
    task automatic stop;
        @(posedge clock);
        m_sda <= 1'b0;
        half;
        rise;
        m_sda <= 1'b1;
        half;
    endtask : stop
endmodule : isrp_master_model
`default_nettype wire

// ==== tb/i2c_slave_receive_path_tb.sv ====
// Testbench of the I2C slave receive path
`include "isrp_cfg.svh"
`default_nettype none
module i2c_slave_receive_path_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock, rst_n, clk_en, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       scl_oe, sda_oe, event_flag, m_scl, m_sda, scl_w, sda_w, ack;
    int         failures, total_checks;

    // Open-drain wires: pull-ups win unless someone pulls low
    assign scl_w = m_scl & ~scl_oe;
    assign sda_w = m_sda & ~sda_oe;

    isrp_top DUT (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
        .sda_oe(sda_oe), .event_flag(event_flag)
    );
    isrp_master_model m (.clock(clock), .scl_w(scl_w), .sda_w(sda_w), .m_scl(m_scl), .m_sda(m_sda));

    // 100 MHz clock
    initial clock = 1'b0;
    always #5 clock = ~clock;

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic chb(input logic g, input logic e);
        chk({7'h00, g}, {7'h00, e});
    endtask : chb

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdm(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata & mask, e);
    endtask : rdm

    // Answers land 3 to 4 cycles after a seen SCL edge
    task automatic sett;
        repeat (6) @(posedge clock);
        #1;
    endtask : sett

    task automatic xfer(input logic [7:0] b, input logic e);
        m.bits8(b);
        m.ackbit(ack);
        chb(ack, e);
        sett;
    endtask : xfer

    task automatic finish_test;
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // Watchdog far beyond the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge clock);
        failures++;
        finish_test;
    end

    initial begin
        rst_n = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 4'h0; reg_wdata = 8'h00; failures = 0; total_checks = 0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        rdm(`ISRP_A_CON2, 8'hff, `ISRP_CON2_RST);
        rdm(4'hf, 8'hff, 8'h00);
        wr(`ISRP_A_OWN, 8'h84);
        wr(`ISRP_A_CON2, 8'h01);
        wr(`ISRP_A_CON3, 8'h20);
        m.start();
        sett;
        chb(event_flag, 1'b1);
        rdm(`ISRP_A_STAT, 8'h08, 8'h08);
        wr(`ISRP_A_EVT, 8'h00);
        xfer(8'h84, 1'b0);
        chb(event_flag, 1'b1);
        chb(scl_oe, 1'b1);
        rdm(`ISRP_A_STAT, 8'h05, 8'h01);
        rdm(`ISRP_A_CON2, 8'h40, 8'h00);
        wr(`ISRP_A_CON2, 8'h03);
        rdm(`ISRP_A_CON2, 8'hff, 8'h01);
        wr(`ISRP_A_BUF, 8'h77);
        rdm(`ISRP_A_BUF, 8'hff, 8'h84);
        rdm(`ISRP_A_STAT, 8'h01, 8'h00);
        wr(`ISRP_A_EVT, 8'h00);
        wr(`ISRP_A_CON1, 8'h10);
        sett;
        chb(scl_oe, 1'b0);
        xfer(8'h5a, 1'b0);
        chb(event_flag, 1'b1);
        rdm(`ISRP_A_STAT, 8'h21, 8'h21);
        wr(`ISRP_A_EVT, 8'h00);
        wr(`ISRP_A_CON1, 8'h10);
        wr(`ISRP_A_CON3, 8'h00);
        m.stop();
        sett;
        rdm(`ISRP_A_STAT, 8'h10, 8'h10);
        chb(event_flag, 1'b0);
        // Buffer still full: the address must be refused
        m.start();
        xfer(8'h84, 1'b1);
        chb(event_flag, 1'b0);
        rdm(`ISRP_A_CON2, 8'h40, 8'h40);
        rdm(`ISRP_A_CON1, 8'h40, 8'h40);
        m.stop();
        wr(`ISRP_A_CON1, 8'h10);
        rdm(`ISRP_A_BUF, 8'hff, 8'h5a);
        m.start();
        xfer(8'h86, 1'b1);
        chb(event_flag, 1'b0);
        m.stop();
        wr(`ISRP_A_CON2, 8'h81);
        m.start();
        xfer(8'h00, 1'b0);
        chb(event_flag, 1'b1);
        rdm(`ISRP_A_BUF, 8'hff, 8'h00);
        wr(`ISRP_A_EVT, 8'h00);
        wr(`ISRP_A_CON1, 8'h10);
        m.stop();
        // Address and data hold with stretching
        wr(`ISRP_A_CON2, 8'h01);
        wr(`ISRP_A_CON3, 8'h03);
        m.start();
        m.bits8(8'h84);
        sett;
        chb(event_flag, 1'b1);
        chb(scl_oe, 1'b1);
        rdm(`ISRP_A_CON1, 8'h10, 8'h00);
        rdm(`ISRP_A_CON3, 8'h80, 8'h80);
        rdm(`ISRP_A_BUF, 8'hff, 8'h84);
        wr(`ISRP_A_EVT, 8'h00);
        wr(`ISRP_A_CON1, 8'h10);
        m.ackbit(ack);
        chb(ack, 1'b0);
        sett;
        chb(event_flag, 1'b1);
        chb(scl_oe, 1'b1);
        rdm(`ISRP_A_CON3, 8'h80, 8'h00);
        wr(`ISRP_A_EVT, 8'h00);
        wr(`ISRP_A_CON1, 8'h10);
        m.bits8(8'h33);
        sett;
        chb(event_flag, 1'b1);
        rdm(`ISRP_A_CON1, 8'h10, 8'h00);
        rdm(`ISRP_A_BUF, 8'hff, 8'h33);
        wr(`ISRP_A_EVT, 8'h00);
        wr(`ISRP_A_CON2, 8'h21);
        wr(`ISRP_A_CON1, 8'h10);
        m.ackbit(ack);
        chb(ack, 1'b1);
        sett;
        chb(event_flag, 1'b0);
        m.stop();
        // Master mode: triggers clear themselves, receive enable stays
        wr(`ISRP_A_CON3, 8'h00);
        wr(`ISRP_A_CON1, 8'h18);
        wr(`ISRP_A_CON2, 8'h1f);
        sett;
        rdm(`ISRP_A_CON2, 8'h1f, 8'h08);
        finish_test;
    end
endmodule : i2c_slave_receive_path_tb
`default_nettype wire
